//--- inc/i2c_tgt_pkg.sv
// Operation
// - stretch on: hold clock low now if low, else from next fall
// - early mode: transmit request right after rise of direction bit
// - writing one to control clear bit wipes broadcast flag and kind, unless a set comes in the same cycle
// - broadcast flag and kind change only by set, clear, full reset
// - both broadcast enables: compare alternate id to second byte, match flags
// - broadcast address zero with write acked only while broadcast enable set
// - seven-bit mode matches any of four address registers
// - ten-bit mode matches registers zero and one, zero begins 11110
// - ten-bit mode still matches registers two and three as seven-bit
// - target enable low holds every state machine flop in reset except rx_q, which keeps its value
// - broadcast kind 00 none, 01 reset, 10 program, 11 alternate
// - any broadcast sets the flag, which always raises the interrupt
package i2c_tgt_pkg;

	localparam int WB_AW = 8;
	localparam int WB_DW = 32;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_ALT = 8'h08;
	localparam logic [7:0] ADDR_ID0 = 8'h0c;
	localparam logic [7:0] ADDR_ID1 = 8'h10;
	localparam logic [7:0] ADDR_ID2 = 8'h14;
	localparam logic [7:0] ADDR_ID3 = 8'h18;
	localparam logic [7:0] ADDR_ISTS = 8'h1c;
	localparam logic [7:0] ADDR_IMSK = 8'h20;
	localparam logic [7:0] ADDR_RXD = 8'h24;
	localparam logic [7:0] ADDR_TXD = 8'h28;

	// control bit positions
	localparam int CTL_EN = 0;
	localparam int CTL_TEN = 1;
	localparam int CTL_GC = 2;
	localparam int CTL_HGC = 3;
	localparam int CTL_GCCLR = 4;
	localparam int CTL_EARLY = 5;
	localparam int CTL_STRETCH = 6;
	localparam logic [15:0] CTRL_RST = 16'h0000;

	// status bit positions
	localparam int STAT_IDX = 0;
	localparam int STAT_BUSY = 6;
	localparam int STAT_FLAG = 7;
	localparam int STAT_KIND = 8;

	// event bits, shared by sticky status and mask
	localparam int EV_MATCH = 0;
	localparam int EV_RX = 1;
	localparam int EV_TX = 2;
	localparam int EV_STOP = 3;
	localparam int EV_N = 4;

	localparam logic [7:0] REG8_RST = 8'h00;
	localparam logic [7:0] BC_ADDR = 8'h00;
	localparam logic [7:0] BC_RESET_PROG = 8'h06;
	localparam logic [7:0] BC_PROG = 8'h04;
	localparam logic [4:0] TEN_HDR = 5'h1e;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] DATA_BITS = 4'h8;

	typedef enum logic [1:0] {
		KIND_NONE = 2'b00,
		KIND_RESET_PROG = 2'b01,
		KIND_PROG = 2'b10,
		KIND_ALT = 2'b11
	} bc_kind_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_ADDR2 = 4'b0010,
		ST_RX = 4'b0011,
		ST_ACK = 4'b0100,
		ST_TX = 4'b0101,
		ST_ACK_TX = 4'b0110
	} state_t;

endpackage

//--- verilog/line_sync.sv
`timescale 1ns/1ns
`default_nettype none
module line_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic line_i,
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	// first stage feeds only the second; idle bus is high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			prev_q <= 1'b1;
		end else begin
			meta_q <= line_i;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level_o = sync_q;
	assign rise_o = sync_q & ~prev_q;
	assign fall_o = ~sync_q & prev_q;
endmodule
`default_nettype wire

//--- verilog/addr_cmp.sv
`timescale 1ns/1ns
`default_nettype none
module addr_cmp (
	input wire logic en_i,
	input wire logic [7:0] byte_i,
	input wire logic [7:0] id_i,
	output logic hit_o
);
	// address sits in bits 7:1, bit 0 is the direction
	assign hit_o = en_i & (byte_i[7:1] == id_i[7:1]);
endmodule
`default_nettype wire

//--- verilog/i2c_target.sv
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module i2c_target (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [i2c_tgt_pkg::WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [i2c_tgt_pkg::WB_DW-1:0] wb_dat_i,
	output logic [i2c_tgt_pkg::WB_DW-1:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o
);
	import i2c_tgt_pkg::*;

	logic wb_ack_q;
	logic [WB_DW-1:0] wb_dat_q;
	logic irq_q;
	logic scl_oe_q;
	logic sda_oe_q;
	logic line_lo_q;

	logic [15:0] ctrl_q;
	logic [7:0] alt_q;
	logic [3:0][7:0] id_q;
	logic [EV_N-1:0] ev_sts_q;
	logic [EV_N-1:0] ev_mask_q;
	logic [7:0] rx_q;
	logic [7:0] tx_q;
	logic bc_flag_q;
	logic [1:0] bc_kind_q;

	state_t st_q;
	state_t nxt_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [7:0] tx_sh_q;
	logic [3:0] hit_q;
	logic gc_hit_q;
	logic ten1_q;
	logic ten2_q;
	logic ten_done_q;
	logic gc_pend_q;
	logic matched_q;
	logic [1:0] idx_q;
	logic mack_q;
	logic [EV_N-1:0] ev_set_q;
	logic bc_set_q;
	logic [1:0] bc_set_kind_q;

	logic req;
	logic wr;
	logic gc_clr;
	logic fsm_rst;
	logic [WB_DW-1:0] rd_d;
	logic scl_lvl;
	logic scl_rise;
	logic scl_fall;
	logic sda_lvl;
	logic sda_rise;
	logic sda_fall;
	logic start_det;
	logic stop_det;
	logic [7:0] nb;
	logic [3:0] sev_hit;
	logic [1:0] sev_idx;
	logic early;

	assign wb_ack_o = wb_ack_q;
	assign wb_dat_o = wb_dat_q;
	assign irq_o = irq_q;
	assign scl_oe_o = scl_oe_q;
	assign sda_oe_o = sda_oe_q;
	assign scl_o = line_lo_q;
	assign sda_o = line_lo_q;

	// ---------------- wishbone slave, one wait-free ack per request
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_q;
	assign wr = req & wb_we_i;
	assign gc_clr = wr & (wb_adr_i == ADDR_CTRL) & wb_sel_i[0]
		& wb_dat_i[CTL_GCCLR];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_q <= 1'b0;
		end else begin
			wb_ack_q <= req;
		end
	end

	always_comb begin
		rd_d = '0;
		case (wb_adr_i)
			ADDR_CTRL: rd_d[15:0] = ctrl_q;
			ADDR_STAT: begin
				rd_d[STAT_IDX+1:STAT_IDX] = idx_q;
				rd_d[STAT_BUSY] = (st_q != ST_IDLE);
				rd_d[STAT_FLAG] = bc_flag_q;
				rd_d[STAT_KIND+1:STAT_KIND] = bc_kind_q;
			end
			ADDR_ALT: rd_d[7:0] = alt_q;
			ADDR_ID0: rd_d[7:0] = id_q[0];
			ADDR_ID1: rd_d[7:0] = id_q[1];
			ADDR_ID2: rd_d[7:0] = id_q[2];
			ADDR_ID3: rd_d[7:0] = id_q[3];
			ADDR_ISTS: rd_d[EV_N-1:0] = ev_sts_q;
			ADDR_IMSK: rd_d[EV_N-1:0] = ev_mask_q;
			ADDR_RXD: rd_d[7:0] = rx_q;
			ADDR_TXD: rd_d[7:0] = tx_q;
			default: rd_d = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_q <= '0;
		end else if (req & ~wb_we_i) begin
			wb_dat_q <= rd_d;
		end
	end

	// clear bit is a strobe, so it never lands in storage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= CTRL_RST;
		end else if (wr & (wb_adr_i == ADDR_CTRL)) begin
			if (wb_sel_i[0]) begin
				ctrl_q[7:0] <= wb_dat_i[7:0] & ~(8'h01 << CTL_GCCLR);
			end
			if (wb_sel_i[1]) begin
				ctrl_q[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// alternate id bit 0 is trusted to be one by software
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alt_q <= REG8_RST;
			id_q <= '0;
			tx_q <= REG8_RST;
			ev_mask_q <= '0;
		end else if (wr & wb_sel_i[0]) begin
			case (wb_adr_i)
				ADDR_ALT: alt_q <= wb_dat_i[7:0];
				ADDR_ID0: id_q[0] <= wb_dat_i[7:0];
				ADDR_ID1: id_q[1] <= wb_dat_i[7:0];
				ADDR_ID2: id_q[2] <= wb_dat_i[7:0];
				ADDR_ID3: id_q[3] <= wb_dat_i[7:0];
				ADDR_TXD: tx_q <= wb_dat_i[7:0];
				ADDR_IMSK: ev_mask_q <= wb_dat_i[EV_N-1:0];
				default: ;
			endcase
		end
	end

	// ---------------- events and interrupt
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ev_sts_q <= '0;
		end else if (wr & wb_sel_i[0] & (wb_adr_i == ADDR_ISTS)) begin
			ev_sts_q <= (ev_sts_q & ~wb_dat_i[EV_N-1:0]) | ev_set_q;
		end else begin
			ev_sts_q <= ev_sts_q | ev_set_q;
		end
	end

	// only a full reset reaches these, not the enable bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bc_flag_q <= 1'b0;
			bc_kind_q <= KIND_NONE;
		end else if (bc_set_q) begin
			bc_flag_q <= 1'b1;
			bc_kind_q <= bc_set_kind_q;
		end else if (gc_clr) begin
			bc_flag_q <= 1'b0;
			bc_kind_q <= KIND_NONE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (|(ev_sts_q & ev_mask_q)) | bc_flag_q;
		end
	end

	// ---------------- bus lines
	line_sync u_scl (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.line_i(scl_i),
		.level_o(scl_lvl),
		.rise_o(scl_rise),
		.fall_o(scl_fall)
	);

	line_sync u_sda (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.line_i(sda_i),
		.level_o(sda_lvl),
		.rise_o(sda_rise),
		.fall_o(sda_fall)
	);

	assign start_det = sda_fall & scl_lvl;
	assign stop_det = sda_rise & scl_lvl;
	assign fsm_rst = rst_i | ~ctrl_q[CTL_EN];
	assign early = ctrl_q[CTL_EARLY];
	assign nb = {sh_q[6:0], sda_lvl};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_lo_q <= 1'b0;
		end else begin
			line_lo_q <= 1'b0;
		end
	end

	// the sampled level lags the pin, so a low clock is caught a few
	// cycles after it falls; from then it is held low until stretch or the enable bit is cleared
	always_ff @(posedge clk_i) begin
		if (fsm_rst) begin
			scl_oe_q <= 1'b0;
		end else if (!ctrl_q[CTL_STRETCH]) begin
			scl_oe_q <= 1'b0;
		end else if (!scl_lvl) begin
			scl_oe_q <= 1'b1;
		end
	end

	// ---------------- address compare
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_cmp
			addr_cmp u_cmp (
				.en_i(~ctrl_q[CTL_TEN] | (gi >= 2)),
				.byte_i(nb),
				.id_i(id_q[gi]),
				.hit_o(sev_hit[gi])
			);
		end
	endgenerate

	always_comb begin
		sev_idx = 2'b00;
		if (hit_q[3]) sev_idx = 2'b11;
		if (hit_q[2]) sev_idx = 2'b10;
		if (hit_q[1]) sev_idx = 2'b01;
		if (hit_q[0]) sev_idx = 2'b00;
	end

	// ---------------- target state machine
	always_ff @(posedge clk_i) begin
		if (fsm_rst) begin
			st_q <= ST_IDLE;
			nxt_q <= ST_IDLE;
			cnt_q <= '0;
			sh_q <= '0;
			tx_sh_q <= '0;
			sda_oe_q <= 1'b0;
			hit_q <= '0;
			gc_hit_q <= 1'b0;
			ten1_q <= 1'b0;
			ten2_q <= 1'b0;
			ten_done_q <= 1'b0;
			gc_pend_q <= 1'b0;
			matched_q <= 1'b0;
			idx_q <= 2'b00;
			mack_q <= 1'b0;
			ev_set_q <= '0;
			bc_set_q <= 1'b0;
			bc_set_kind_q <= KIND_NONE;
		end else begin
			ev_set_q <= '0;
			bc_set_q <= 1'b0;
			if (stop_det) begin
				ev_set_q[EV_STOP] <= matched_q;
				st_q <= ST_IDLE;
				sda_oe_q <= 1'b0;
				matched_q <= 1'b0;
				ten_done_q <= 1'b0;
				gc_pend_q <= 1'b0;
			end else if (start_det) begin
				st_q <= ST_ADDR;
				cnt_q <= '0;
				sda_oe_q <= 1'b0;
				gc_pend_q <= 1'b0;
			end else begin
				case (st_q)
					ST_IDLE: ;
					ST_ADDR, ST_ADDR2, ST_RX: begin
						if (scl_rise) begin
							sh_q <= nb;
							cnt_q <= cnt_q + 4'h1;
							if (cnt_q == LAST_BIT && st_q == ST_ADDR) begin
								hit_q <= sev_hit;
								gc_hit_q <= ctrl_q[CTL_GC] & (nb == BC_ADDR);
								ten1_q <= ctrl_q[CTL_TEN]
									& (nb[7:3] == TEN_HDR)
									& (nb[7:1] == id_q[0][7:1]);
								if (early & nb[0] & ((|sev_hit)
									| (ctrl_q[CTL_TEN] & ten_done_q
									& (nb[7:1] == id_q[0][7:1]))))
									ev_set_q[EV_TX] <= 1'b1;
							end
							if (cnt_q == LAST_BIT && st_q == ST_ADDR2)
								ten2_q <= (nb == id_q[1]);
						end else if (scl_fall && cnt_q == DATA_BITS) begin
							cnt_q <= '0;
							st_q <= ST_ACK;
							sda_oe_q <= 1'b0;
							if (st_q == ST_ADDR) begin
								if (gc_hit_q) begin
									sda_oe_q <= 1'b1;
									nxt_q <= ST_RX;
									gc_pend_q <= 1'b1;
								end else if (|hit_q) begin
									sda_oe_q <= 1'b1;
									nxt_q <= sh_q[0] ? ST_TX : ST_RX;
									matched_q <= 1'b1;
									idx_q <= sev_idx;
									ev_set_q[EV_MATCH] <= 1'b1;
								end else if (ten1_q & ~sh_q[0]) begin
									sda_oe_q <= 1'b1;
									nxt_q <= ST_ADDR2;
								end else if (ten1_q & ten_done_q) begin
									sda_oe_q <= 1'b1;
									nxt_q <= ST_TX;
									ev_set_q[EV_MATCH] <= 1'b1;
								end else begin
									st_q <= ST_IDLE;
								end
							end else if (st_q == ST_ADDR2) begin
								if (ten2_q) begin
									sda_oe_q <= 1'b1;
									nxt_q <= ST_RX;
									ten_done_q <= 1'b1;
									matched_q <= 1'b1;
									idx_q <= 2'b00;
									ev_set_q[EV_MATCH] <= 1'b1;
								end else begin
									st_q <= ST_IDLE;
								end
							end else begin
								sda_oe_q <= 1'b1;
								nxt_q <= ST_RX;
								rx_q <= sh_q;
								ev_set_q[EV_RX] <= 1'b1;
								if (gc_pend_q) begin
									gc_pend_q <= 1'b0;
									bc_set_q <= 1'b1;
									if (ctrl_q[CTL_HGC] & ctrl_q[CTL_GC]
										& (sh_q == alt_q))
										bc_set_kind_q <= KIND_ALT;
									else if (sh_q == BC_RESET_PROG)
										bc_set_kind_q <= KIND_RESET_PROG;
									else if (sh_q == BC_PROG)
										bc_set_kind_q <= KIND_PROG;
									else
										bc_set_kind_q <= KIND_NONE;
								end
							end
						end
					end
					ST_ACK: begin
						if (scl_fall) begin
							st_q <= nxt_q;
							sda_oe_q <= 1'b0;
							if (nxt_q == ST_TX) begin
								tx_sh_q <= tx_q;
								sda_oe_q <= ~tx_q[7];
								if (!early)
									ev_set_q[EV_TX] <= 1'b1;
							end
						end
					end
					ST_TX: begin
						if (scl_rise) begin
							cnt_q <= cnt_q + 4'h1;
						end else if (scl_fall) begin
							if (cnt_q == DATA_BITS) begin
								cnt_q <= '0;
								sda_oe_q <= 1'b0;
								st_q <= ST_ACK_TX;
							end else begin
								tx_sh_q <= {tx_sh_q[6:0], 1'b0};
								sda_oe_q <= ~tx_sh_q[6];
							end
						end
					end
					ST_ACK_TX: begin
						if (scl_rise) begin
							mack_q <= ~sda_lvl;
						end else if (scl_fall) begin
							if (mack_q) begin
								tx_sh_q <= tx_q;
								sda_oe_q <= ~tx_q[7];
								st_q <= ST_TX;
								ev_set_q[EV_TX] <= 1'b1;
							end else begin
								st_q <= ST_IDLE;
							end
						end
					end
					default: st_q <= ST_IDLE;
				endcase
			end
		end
	end

endmodule
`default_nettype wire

//--- sim/i2c_target_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_target_monitor import i2c_tgt_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_AW-1:0] wb_adr_i,
	input wire logic [WB_DW-1:0] wb_dat_i,
	input wire logic [WB_DW-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic irq_o,
	input wire logic scl_i,
	input wire logic scl_oe_o,
	input wire logic sda_i,
	input wire logic sda_oe_o
);
	logic [7:0] ctl_q;
	logic rd_st_q, clr_q, flag_q, sda_q, tk, wr_ctl;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_ctl = tk && wb_we_i && wb_adr_i == ADDR_CTRL;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_q <= 8'h00;
		end else if (wr_ctl) begin
			ctl_q <= wb_dat_i[7:0];
		end
	end
	always_ff @(posedge clk_i) begin
		sda_q <= sda_i;
		if (tk) begin
			rd_st_q <= !wb_we_i && wb_adr_i == ADDR_STAT;
		end
	end
	// any start ends the window in which a cleared flag must read zero
	always_ff @(posedge clk_i) begin
		if (rst_i || (scl_i && sda_q && !sda_i)) begin
			clr_q <= 1'b0;
		end else if (wr_ctl && wb_dat_i[CTL_GCCLR]) begin
			clr_q <= 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || (wr_ctl && wb_dat_i[CTL_GCCLR])) begin
			flag_q <= 1'b0;
		end else if (wb_ack_o && rd_st_q && wb_dat_o[STAT_FLAG]) begin
			flag_q <= 1'b1;
		end
	end
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_low;
		ctl_q[CTL_EN] && ctl_q[CTL_STRETCH] && !scl_i;
	endsequence
	a_ack_follows: assert property (s_req |=> wb_ack_o)
		else $error("no ack after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
		!wb_ack_o && !irq_o && !scl_oe_o && !sda_oe_o)
		else $error("outputs active after reset");
	a_stretch_hold: assert property (s_low [*4] |-> ##[0:4] scl_oe_o)
		else $error("clock line not held");
	a_stretch_free: assert property (
		!ctl_q[CTL_STRETCH] |=> !scl_oe_o)
		else $error("clock line held without stretch");
	a_off_quiet: assert property (
		!ctl_q[CTL_EN] |=> !scl_oe_o && !sda_oe_o)
		else $error("disabled target drives a line");
	a_flag_irq: assert property (
		wb_ack_o && rd_st_q && wb_dat_o[STAT_FLAG] |-> irq_o)
		else $error("flag set without interrupt");
	a_clear_wipes: assert property (
		wb_ack_o && rd_st_q && clr_q
		|-> wb_dat_o[STAT_KIND+1:STAT_FLAG] == 3'h0)
		else $error("flag or kind survives clear");
	a_flag_keeps: assert property (
		wb_ack_o && rd_st_q && flag_q |-> wb_dat_o[STAT_FLAG])
		else $error("flag lost without clear");
endmodule
bind i2c_target i2c_target_monitor u_mon (.*);
`default_nettype wire

//--- sim/i2c_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
	input wire logic clk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_lo_o,
	output logic sda_lo_o,
	output int bits_o
);
	initial begin
		scl_lo_o = 1'b0;
		sda_lo_o = 1'b0;
		bits_o = 0;
	end
	task automatic qtr();
		repeat (4) @(posedge clk_i);
	endtask
	// a stretching target may hold the clock low; bounded wait
	task automatic rise();
		scl_lo_o <= 1'b0;
		for (int i = 0; i < 3000 && !scl_i; i++) @(posedge clk_i);
	endtask
	task automatic xbit(input logic b, output logic r);
		sda_lo_o <= !b;
		qtr();
		rise();
		bits_o <= bits_o + 1;
		qtr();
		r = sda_i;
		qtr();
		scl_lo_o <= 1'b1;
		qtr();
	endtask
	task automatic start();
		sda_lo_o <= 1'b1;
		bits_o <= 0;
		qtr();
		scl_lo_o <= 1'b1;
		qtr();
	endtask
	task automatic stop();
		sda_lo_o <= 1'b1;
		qtr();
		rise();
		qtr();
		sda_lo_o <= 1'b0;
		qtr();
	endtask
	task automatic wbyte(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) xbit(v[i], r);
		xbit(1'b1, r);
		ack = !r;
	endtask
endmodule
`default_nettype wire

//--- sim/tb_i2c_target_control_options.sv
`timescale 1ns/1ns
`default_nettype none
module tb_i2c_target_control_options;
	import i2c_tgt_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] rdat, r, k;
	logic ack, irq, scl_oe, sda_oe, m_scl, m_sda, scl_w, sda_w, a;
	logic scl_d, sda_d;
	logic [7:0] d, alt;
	logic [7:0] id[4];
	logic [7:0] c[4];
	logic [63:0] x;
	logic [63:0] q[$];
	int bits, fail_count = 0, n_checks = 0, cyc_n = 0;
	// open-drain lines with pull-ups
	assign scl_w = !m_scl && (!scl_oe || scl_d);
	assign sda_w = !m_sda && (!sda_oe || sda_d);
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	i2c_target dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
		.scl_i(scl_w), .scl_o(scl_d), .scl_oe_o(scl_oe), .sda_i(sda_w),
		.sda_o(sda_d), .sda_oe_o(sda_oe));
	i2c_master_model m (.clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w),
		.scl_lo_o(m_scl), .sda_lo_o(m_sda), .bits_o(bits));
	task automatic check(input string n, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] ad,
		input logic [31:0] wd, mk = 0, e = 0);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= ad;
		dat <= wd;
		if (!w) q.push_back({mk, e & mk});
		n = 0;
		// hold the request until ack is seen high at a rising edge
		do begin
			@(posedge clk_i);
			n++;
		end while (!ack && n < 20);
		if (!ack) check("wb ack", 32'(ack), 32'h0000_0001);
		cyc <= 1'b0;
	endtask
	// tx request bit of the event status, taken from the interrupt output
	function automatic logic [31:0] ev_read();
		return 32'(irq) << EV_TX;
	endfunction
	task automatic send(input logic [7:0] b, input logic e);
		m.wbyte(b, a);
		check("ack", 32'(a), 32'(e));
	endtask
	always @(posedge clk_i) begin
		if (ack && !we && q.size() > 0) begin
			x = q.pop_front();
			check($sformatf("reg %h", adr), rdat & x[63:32], x[31:0]);
		end
	end
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 30000) begin
			fail_count++;
			final_report();
		end
	end
	initial begin
		void'($urandom(32'h19b1_aa69));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		r = $urandom;
		bus(1'b0, ADDR_CTRL, 0, 32'h0000_ffff, 0);
		bus(1'b0, 8'h30, 0, 32'hffff_ffff, 0);
		bus(1'b1, ADDR_CTRL, {16'h0, r[15:7], 7'h01});
		bus(1'b0, ADDR_CTRL, 0, 32'h0000_ffff, {16'h0, r[15:7], 7'h01});
		for (int i = 0; i < 4; i++) begin
			id[i] = {2'b01, 2'(i), r[2:0], 1'b0};
			bus(1'b1, ADDR_ID0 + 8'(4 * i), 32'(id[i]));
			d = 8'($urandom);
			m.start();
			send(id[i], 1'b1);
			send(d, 1'b1);
			m.stop();
			bus(1'b0, ADDR_RXD, 0, 32'h0000_00ff, 32'(d));
		end
		m.start();
		send(8'hc0, 1'b0);
		m.stop();
		bus(1'b1, ADDR_CTRL, 0);
		m.start();
		send(id[2], 1'b0);
		m.stop();
		$display("seven-bit test done");
		bus(1'b1, ADDR_CTRL, 32'h0000_0003);
		bus(1'b1, ADDR_ID0, 32'h0000_00f2);
		// top bit set keeps id1 clear of the broadcast address later
		bus(1'b1, ADDR_ID1, 32'({1'b1, r[22:16]}));
		for (int j = 0; j < 2; j++) begin
			m.start();
			send(8'hf2, 1'b1);
			send({1'b1, r[22:16]} ^ 8'(j), 1'(j == 0));
			m.stop();
		end
		m.start();
		send(id[2], 1'b1);
		m.stop();
		$display("ten-bit test done");
		bus(1'b1, ADDR_CTRL, 32'h0000_0001);
		m.start();
		send(8'h00, 1'b0);
		m.stop();
		alt = {r[30:24], 1'b1};
		bus(1'b1, ADDR_ALT, 32'(alt));
		c = '{8'h06, 8'h04, alt, 8'h02};
		for (int i = 0; i < 4; i++) begin
			k = 32'({2'(i + 1), 1'b1}) << 7;
			bus(1'b1, ADDR_CTRL, 32'h0000_000d);
			m.start();
			send(8'h00, 1'b1);
			send(c[i], 1'b1);
			m.stop();
			bus(1'b0, ADDR_STAT, 0, 32'h0000_0380, k);
			check("irq", 32'(irq), 1);
			bus(1'b1, ADDR_CTRL, 0);
			bus(1'b0, ADDR_STAT, 0, 32'h0000_0380, k);
			bus(1'b1, ADDR_CTRL, 32'h0000_0010);
			bus(1'b0, ADDR_STAT, 0, 32'h0000_0380, 0);
		end
		$display("broadcast test done");
		bus(1'b1, ADDR_CTRL, 32'h0000_0041);
		m.start();
		repeat (10) @(posedge clk_i);
		check("stretch", 32'(scl_oe), 1);
		bus(1'b1, ADDR_CTRL, 32'h0000_0001);
		// registered output moves at the edge the bus task returns on
		repeat (2) @(posedge clk_i);
		check("release", 32'(scl_oe), 0);
		m.stop();
		$display("stretch test done");
		// all ones so the target never blocks the master's stop
		bus(1'b1, ADDR_TXD, 32'h0000_00ff);
		for (int e = 0; e < 2; e++) begin
			bus(1'b1, ADDR_CTRL, e ? 32'h0000_0021 : 32'h0000_0001);
			bus(1'b1, ADDR_ISTS, 32'h0000_000f);
			bus(1'b1, ADDR_IMSK, 32'h0000_0004);
			fork
				begin
					m.start();
					send({id[2][7:1], 1'b1}, 1'b1);
				end
				begin
					wait (bits == 8);
					repeat (7) @(posedge clk_i);
					check("early", 32'(irq), 32'(e));
				end
			join
			m.stop();
			check("tx irq", 32'(irq), 1);
			check("tx sts", ev_read(), 32'h0000_0004);
			bus(1'b1, ADDR_IMSK, 0);
			repeat (2) @(posedge clk_i);
			check("masked", 32'(irq), 0);
			bus(1'b1, ADDR_ISTS, 32'h0000_000f);
			bus(1'b1, ADDR_IMSK, 32'h0000_0004);
			repeat (2) @(posedge clk_i);
			check("cleared", 32'(irq), 0);
		end
		$display("early request test done");
		final_report();
	end
endmodule
`default_nettype wire
